// ===== rtl/apd_axis_profiler.sv
`timescale 1ns/10ps
`default_nettype none
`include "apd_defs.svh"

// Summary of operation
// RL1 - Fixed drive emits exactly the written count
// RL2 - Decelerate when remaining reaches acceleration pulses
// RL3 - Equal rates need no separate deceleration value
// RL4 - New count extends drive or halts at once
// RL5 - Count change may cut S-curve deceleration short
// RL6 - Manual mode uses host deceleration point
// RL7 - Offset advances automatic deceleration start
// RL8 - Offset resets to eight pulses
// RL9 - Continuous drive runs until stop
// RL10 - Continuous drive follows new speed anytime
// RL11 - Decelerating stop and sudden stop commands; a ramped fixed drive only slows to initial speed and runs out its count, a flat one halts at once
// RL12 - Each stop input has enable and level
// RL13 - Z-phase on input two, home sensors lower
// RL14 - Stop input while ramping gives decelerating stop; a fixed drive slows to initial speed and runs out its count
// RL15 - Stop input at constant speed halts abruptly
// RL16 - Drive below initial speed means constant speed
// RL17 - Symmetric ramp up and down at slope
// RL18 - Deceleration may start straight from acceleration
// RL19 - Triangle prevention holds speed past half count
// RL20 - Triangle prevention off until mode bit set
// RL21 - Host clears triangle bit before continuous drive
// RL22 - Separate deceleration rate when its bit set
// RL23 - Mode bit selects S-curve profile
// RL24 - Busy clears after final pulse cycle ends
module apd_axis_profiler
	import apd_pkg::*;
#(
	parameter int CNT_W = 32,   // Pulse count width
	parameter int SPD_W = 16,   // Speed value width
	parameter int ACC_W = 20    // Rate accumulator width
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst_n,
	// Mode registers
	input  wire logic [5:0]       drive_mode_register,
	input  wire logic [5:0]       stop_input_mode_register,
	// Speed profile parameters
	input  wire logic [SPD_W-1:0] initial_speed_param,
	input  wire logic [SPD_W-1:0] drive_speed,
	input  wire logic [SPD_W-1:0] accel_rate,
	input  wire logic [SPD_W-1:0] decel_rate,
	// Pulse count and deceleration point
	input  wire logic [CNT_W-1:0] pulse_count,
	input  wire logic             pulse_count_write,
	input  wire logic [CNT_W-1:0] manual_decel_point,
	// Acceleration counter offset
	input  wire logic [15:0]      offset_value,
	input  wire logic             offset_write,
	// Drive commands, one-cycle pulses
	input  wire logic             start_fixed,
	input  wire logic             start_continuous,
	input  wire logic             decel_stop_cmd,
	input  wire logic             sudden_stop_cmd,
	// External stop pins
	input  wire logic             near_home_stop_input,
	input  wire logic             home_stop_input,
	input  wire logic             z_phase_stop_input,
	// Drive outputs and status
	output logic                  drive_pulse,
	output logic                  busy,
	output logic                  accel_phase,
	output logic                  decel_phase,
	output logic [SPD_W-1:0]      current_speed
);

	localparam int RAMP_W  = 16;   // Ramp divider width
	localparam int PULSE_W = 8;    // Pulse stretch width
	localparam logic [RAMP_W-1:0]  RAMP_LAST =
		RAMP_W'(`APD_RAMP_CYC - 1);
	localparam logic [PULSE_W-1:0] PULSE_LEN = PULSE_W'(`APD_PULSE_CYC);

	// Step speed toward a limit by amount, never passing it
	function automatic logic [SPD_W-1:0] step_to(
		input logic [SPD_W-1:0] cur,
		input logic [SPD_W-1:0] amt,
		input logic [SPD_W-1:0] lim
	);
		logic [SPD_W:0] sum;
		logic [SPD_W:0] dif;
		sum = {1'b0, cur} + {1'b0, amt};
		dif = {1'b0, cur} - {1'b0, amt};
		if (cur < lim) begin
			step_to = (sum > {1'b0, lim}) ? lim : sum[SPD_W-1:0];
		end else begin
			step_to = (dif[SPD_W] || dif < {1'b0, lim}) ? lim :
				dif[SPD_W-1:0];
		end
	endfunction : step_to

	// State and drive registers
	apd_state_t        state_reg, state_next;
	logic              cont_reg, cont_next;         // Continuous drive
	logic              stopping_reg, stopping_next; // Decel stop pending
	logic              const_reg, const_next;       // Constant-speed run
	logic [CNT_W-1:0]  total_reg, total_next;       // Pulses to emit
	logic [CNT_W-1:0]  sent_reg, sent_next;         // Pulses emitted
	logic [CNT_W-1:0]  accp_reg, accp_next;         // Pulses in accel
	logic [SPD_W-1:0]  speed_reg, speed_next;       // Present rate
	logic [SPD_W-1:0]  slope_reg, slope_next;       // Present slope
	logic signed [15:0] offset_reg;                 // Decel offset
	logic [RAMP_W-1:0] ramp_cnt_reg;                // Ramp divider
	logic [PULSE_W-1:0] pulse_cnt_reg;              // Pulse stretcher
	logic              busy_reg, acc_ph_reg, dec_ph_reg, pulse_reg;
	logic [2:0]        stop_s1_reg, stop_s2_reg;    // Pin synchroniser

	// Decoded mode and helper wires
	logic              manual_dec, sep_dec, scurve, tri_en;
	logic              running, fire, ramp_en, ext_stop;
	logic [2:0]        stop_pins, stop_hit;
	logic [CNT_W-1:0]  sent_inc, remaining;
	logic [CNT_W+1:0]  auto_point;
	logic              at_decel_pt, tri_hit;
	logic [SPD_W-1:0]  slope_lim, slope_step, dec_floor;
	logic [SPD_W-1:0]  up_speed, down_speed;

	apd_rate_if #(.SPD_W(SPD_W)) rate_bus ();

	apd_rate_gen #(
		.SPD_W (SPD_W),
		.ACC_W (ACC_W)
	) u_rate (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.rate    (rate_bus.gen)
	);

	// Mode bit decode
	assign manual_dec = drive_mode_register[`APD_DM_MANUAL_DECEL];
	assign sep_dec    = drive_mode_register[`APD_DM_SEP_DECEL];
	assign scurve     = drive_mode_register[`APD_DM_SCURVE];
	// RL20 triangle prevention only with its bit
	assign tri_en     = drive_mode_register[`APD_DM_TRI_PREVENT];

	// Pin order: 0 near home, 1 home, 2 Z-phase
	// RL13 pin order
	assign stop_pins = {z_phase_stop_input, home_stop_input,
		near_home_stop_input};

	// RL12 per-input enable and active level
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_stop
			assign stop_hit[gi] =
				stop_input_mode_register[`APD_SM_EN_BIT(gi)] &&
				(stop_s2_reg[gi] ==
				stop_input_mode_register[`APD_SM_LVL_BIT(gi)]);
		end
	endgenerate
	assign ext_stop = |stop_hit;

	// Pulse bookkeeping
	assign running   = (state_reg == APD_ACCEL) ||
		(state_reg == APD_CONST) || (state_reg == APD_DECEL);
	assign fire      = running && rate_bus.tick;
	assign sent_inc  = sent_reg + CNT_W'(fire);
	assign remaining = (total_reg > sent_inc) ? total_reg - sent_inc : '0;
	assign ramp_en   = (ramp_cnt_reg == RAMP_LAST);

	// RL2 auto point counts acceleration pulses
	// RL7 signed offset moves the point
	assign auto_point = {2'b00, accp_reg} +
		{{(CNT_W - 14){offset_reg[15]}}, offset_reg};
	// RL6 manual point replaces the computed one
	assign at_decel_pt = manual_dec ?
		(remaining <= manual_decel_point) :
		(auto_point[CNT_W+1] ? 1'b1 :
		({2'b00, remaining} <= auto_point));
	// RL19 accel plus decel pulses above half of total
	assign tri_hit = tri_en && !cont_reg &&
		({accp_reg, 2'b00} > {2'b00, total_reg});

	// RL22 separate deceleration rate; RL3 else accel rate
	assign slope_lim  = (state_reg == APD_DECEL && sep_dec) ?
		decel_rate : accel_rate;
	// RL23 S-curve grows the slope one step per ramp tick
	assign slope_step = scurve ?
		step_to(slope_reg, SPD_W'(1), slope_lim) :
		slope_lim;
	// Continuous drive settles at the new speed, stops at initial
	assign dec_floor  = (cont_reg && !stopping_reg &&
		drive_speed > initial_speed_param) ? drive_speed :
		initial_speed_param;
	// RL17 same slope up and down
	assign up_speed   = step_to(speed_reg, slope_step, drive_speed);
	assign down_speed = step_to(speed_reg, slope_step, dec_floor);

	assign rate_bus.run   = running;
	assign rate_bus.speed = speed_reg;

	// Drive sequencer next-state logic; later items take priority
	always_comb begin
		state_next    = state_reg;
		cont_next     = cont_reg;
		stopping_next = stopping_reg;
		const_next    = const_reg;
		total_next    = total_reg;
		sent_next     = sent_reg;
		accp_next     = accp_reg;
		speed_next    = speed_reg;
		slope_next    = slope_reg;
		unique case (state_reg)
			APD_IDLE: begin
				if (start_fixed || start_continuous) begin
					cont_next     = start_continuous;
					stopping_next = 1'b0;
					total_next    = pulse_count;
					sent_next     = '0;
					accp_next     = '0;
					slope_next    = '0;
					// RL16 drive not above initial: no ramp
					const_next = (drive_speed <= initial_speed_param);
					speed_next = const_next ? drive_speed :
						initial_speed_param;
					state_next = const_next ? APD_CONST : APD_ACCEL;
					if (!start_continuous && pulse_count == '0) begin
						state_next = APD_TAIL;
					end
				end
			end
			APD_ACCEL, APD_CONST, APD_DECEL: begin
				sent_next = sent_inc;
				if (state_reg == APD_ACCEL && fire) begin
					accp_next = accp_reg + 1'b1;
				end
				// Ramp the rate on the slow enable
				if (ramp_en && state_reg == APD_ACCEL) begin
					speed_next = up_speed;
					slope_next = slope_step;
					if (up_speed == drive_speed) begin
						state_next = APD_CONST;
					end
				end
				if (ramp_en && state_reg == APD_DECEL) begin
					speed_next = down_speed;
					slope_next = slope_step;
					if (cont_reg && down_speed == dec_floor) begin
						state_next = stopping_reg ? APD_TAIL : APD_CONST;
					end
				end
				// RL19 hold constant speed instead of a triangle
				if (state_reg == APD_ACCEL && tri_hit) begin
					state_next = APD_CONST;
				end
				// RL10 continuous drive chases a new speed
				if (state_reg == APD_CONST && cont_reg && !const_reg &&
					!stopping_reg) begin
					if (drive_speed > speed_reg) begin
						state_next = APD_ACCEL;
					end else if (dec_floor < speed_reg) begin
						state_next = APD_DECEL;
						slope_next = '0;
					end
				end
				// RL10 flat continuous drive takes new speed directly
				if (state_reg == APD_CONST && cont_reg && const_reg) begin
					speed_next = drive_speed;
				end
				// RL18 deceleration may start from acceleration
				if (!cont_reg && !const_reg && at_decel_pt &&
					state_reg != APD_DECEL) begin
					state_next = APD_DECEL;
					slope_next = '0;
				end
				// RL11 decelerating stop; RL14 stop pin while ramping; only continuous drive then stops, fixed drive runs out its count
				if ((decel_stop_cmd || ext_stop) && !const_reg) begin
					stopping_next = 1'b1;
					if (state_reg != APD_DECEL) begin
						state_next = APD_DECEL;
						slope_next = '0;
					end
				end
				// RL15 stop pin at constant speed halts abruptly
				if ((decel_stop_cmd || ext_stop) && const_reg) begin
					state_next = APD_TAIL;
				end
				// RL4 count change; RL5 S-curve may be cut short
				if (pulse_count_write && !cont_reg) begin
					total_next = pulse_count;
					if (pulse_count <= sent_inc) begin
						state_next = APD_TAIL;
					end
				end else if (!cont_reg && sent_inc >= total_reg) begin
					// RL1 end once the last pulse is out
					state_next = APD_TAIL;
				end
				// RL9 continuous runs until told; RL11 sudden stop
				if (sudden_stop_cmd) begin
					state_next = APD_TAIL;
				end
			end
			APD_TAIL: begin
				// RL24 wait for the last pulse cycle to end
				if (pulse_cnt_reg == '0) begin
					state_next = APD_IDLE;
				end
			end
			default: begin
				state_next = APD_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg    <= APD_IDLE;
			cont_reg     <= 1'b0;
			stopping_reg <= 1'b0;
			const_reg    <= 1'b0;
			total_reg    <= '0;
			sent_reg     <= '0;
			accp_reg     <= '0;
			speed_reg    <= '0;
			slope_reg    <= '0;
		end else begin
			state_reg    <= state_next;
			cont_reg     <= cont_next;
			stopping_reg <= stopping_next;
			const_reg    <= const_next;
			total_reg    <= total_next;
			sent_reg     <= sent_next;
			accp_reg     <= accp_next;
			speed_reg    <= speed_next;
			slope_reg    <= slope_next;
		end
	end

	// RL8 offset holds eight pulses until rewritten
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			offset_reg <= `APD_OFFSET_RST;
		end else if (offset_write) begin
			offset_reg <= offset_value;
		end
	end

	// Ramp divider; restarts at each drive so ramps line up
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ramp_cnt_reg <= '0;
		end else if (!running || ramp_en) begin
			ramp_cnt_reg <= '0;
		end else begin
			ramp_cnt_reg <= ramp_cnt_reg + 1'b1;
		end
	end

	// Two-flop synchroniser; only the second stage is decoded
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_s1_reg <= '0;
			stop_s2_reg <= '0;
		end else begin
			stop_s1_reg <= stop_pins;
			stop_s2_reg <= stop_s1_reg;
		end
	end

	// Pulse stretcher; a tick retriggers it, so speeds near the
	// pulse width merge pulses rather than drop them silently
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pulse_cnt_reg <= '0;
		end else if (fire) begin
			pulse_cnt_reg <= PULSE_LEN;
		end else if (pulse_cnt_reg != '0) begin
			pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
		end
	end

	// Registered outputs
	// RL24 busy follows the sequencer, cleared only from tail
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg   <= 1'b0;
			acc_ph_reg <= 1'b0;
			dec_ph_reg <= 1'b0;
			pulse_reg  <= 1'b0;
		end else begin
			busy_reg   <= (state_next != APD_IDLE);
			acc_ph_reg <= (state_next == APD_ACCEL);
			dec_ph_reg <= (state_next == APD_DECEL);
			pulse_reg  <= fire || (pulse_cnt_reg > 8'h01);
		end
	end

	assign drive_pulse   = pulse_reg;
	assign busy          = busy_reg;
	assign accel_phase   = acc_ph_reg;
	assign decel_phase   = dec_ph_reg;
	assign current_speed = speed_reg;

endmodule : apd_axis_profiler

`default_nettype wire

// ===== rtl/apd_defs.svh
`ifndef APD_DEFS_SVH
`define APD_DEFS_SVH

// Drive mode register bit positions
`define APD_DM_MANUAL_DECEL   0
`define APD_DM_SEP_DECEL      1
`define APD_DM_SCURVE         2
`define APD_DM_TRI_PREVENT    5

// Stop input mode register: enable at 2n, active level at 2n+1
`define APD_SM_EN_BIT(n)      (2 * (n))
`define APD_SM_LVL_BIT(n)     (2 * (n) + 1)

// Acceleration counter offset after reset, in pulses
`define APD_OFFSET_RST        16'sh0008

// System clock period in nanoseconds (20 MHz)
`define APD_CLK_NS            50
// Speed ramp update interval, in nanoseconds
`define APD_RAMP_NS           100000
// Ramp interval in clock cycles (longest time, rounds down)
`define APD_RAMP_CYC          (`APD_RAMP_NS / `APD_CLK_NS)
// Least high time of one drive pulse, in nanoseconds
`define APD_PULSE_NS          500
// Pulse high time in clock cycles (least time, rounds up)
`define APD_PULSE_CYC   ((`APD_PULSE_NS + `APD_CLK_NS - 1) / `APD_CLK_NS)

`endif

// ===== rtl/apd_pkg.sv
package apd_pkg;

	// Drive sequencer states
	typedef enum logic [2:0] {
		APD_IDLE,
		APD_ACCEL,
		APD_CONST,
		APD_DECEL,
		APD_TAIL
	} apd_state_t;

endpackage : apd_pkg

// ===== rtl/apd_rate_gen.sv
`timescale 1ns/10ps
`default_nettype none

// Phase accumulator: tick rate = speed * f_clk / 2**ACC_W
module apd_rate_gen #(
	parameter int SPD_W = 16,
	parameter int ACC_W = 20
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Rate link to the profiler
	apd_rate_if.gen   rate
);

	logic [ACC_W-1:0] phase_reg;   // Fractional pulse phase
	logic [ACC_W:0]   phase_sum;   // Phase plus carry
	logic             tick_reg;    // Registered carry

	// Carry out of the accumulator marks a pulse
	assign phase_sum = {1'b0, phase_reg} + {{(ACC_W + 1 - SPD_W){1'b0}},
		rate.speed};
	assign rate.tick = tick_reg;

	// Phase restarts while idle so the first pulse is not early
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_reg <= '0;
			tick_reg  <= 1'b0;
		end else if (!rate.run) begin
			phase_reg <= '0;
			tick_reg  <= 1'b0;
		end else begin
			phase_reg <= phase_sum[ACC_W-1:0];
			tick_reg  <= phase_sum[ACC_W];
		end
	end

endmodule : apd_rate_gen

`default_nettype wire

// ===== rtl/apd_rate_if.sv
`timescale 1ns/10ps
`default_nettype none

// Speed in, pulse tick out, between profiler and rate generator
interface apd_rate_if #(
	parameter int SPD_W = 16
);
	logic             run;     // Generator enabled
	logic [SPD_W-1:0] speed;   // Current pulse rate
	logic             tick;    // One-cycle pulse due

	modport ctrl (output run, output speed, input tick);
	modport gen  (input run, input speed, output tick);
endinterface : apd_rate_if

`default_nettype wire

// ===== tb/apd_axis_sva.sv
`timescale 1ns/10ps
`default_nettype none

// Pin-level checks on one axis profiler
module apd_axis_sva #(
	parameter int SPD_W = 16	// Speed width
) (
	// Clock and reset
	input wire logic		sys_clk,
	input wire logic		rst_n,
	// Settings and commands
	input wire logic [5:0]		stop_input_mode_register,
	input wire logic [SPD_W-1:0]	initial_speed_param,
	input wire logic [SPD_W-1:0]	drive_speed,
	input wire logic		start_fixed,
	input wire logic		start_continuous,
	input wire logic		decel_stop_cmd,
	input wire logic		sudden_stop_cmd,
	input wire logic		near_home_stop_input,
	input wire logic		home_stop_input,
	// Outputs
	input wire logic		drive_pulse,
	input wire logic		busy,
	input wire logic		accel_phase,
	input wire logic		decel_phase,
	input wire logic [SPD_W-1:0]	current_speed
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	// Stop pins enabled and at their active level
	wire near_act = stop_input_mode_register[0]
		&& near_home_stop_input == stop_input_mode_register[1];
	wire home_act = stop_input_mode_register[2]
		&& home_stop_input == stop_input_mode_register[3];
	// No ramp when drive speed is not above start speed
	wire flat = drive_speed <= initial_speed_param;

	AST_START_BUSY: assert property (
		!busy && (start_fixed || start_continuous) |=> busy)
		else $error("no busy after start");
	AST_PULSE_BUSY: assert property (
		$rose(drive_pulse) |-> busy)
		else $error("pulse while idle");
	AST_IDLE_QUIET: assert property (
		!busy |-> !drive_pulse && !accel_phase && !decel_phase)
		else $error("activity while idle");
	AST_RAMP_PICK: assert property (
		$rose(busy) |-> accel_phase == !flat)
		else $error("wrong profile at start");
	AST_SUDDEN_END: assert property (
		sudden_stop_cmd && busy |-> ##[1:24] !busy)
		else $error("sudden stop too slow");
	AST_DECEL_CMD: assert property (
		decel_stop_cmd && accel_phase |-> ##[1:4] decel_phase)
		else $error("no ramp down after stop");
	AST_ACCEL_UP: assert property (
		accel_phase && $past(accel_phase)
		|-> current_speed >= $past(current_speed))
		else $error("speed fell in ramp up");
	AST_DECEL_DOWN: assert property (
		decel_phase && $past(decel_phase)
		|-> current_speed <= $past(current_speed))
		else $error("speed rose in ramp down");
	AST_PIN_HALT: assert property (
		busy && flat && !accel_phase && !decel_phase && home_act
		|-> ##[1:24] !busy)
		else $error("home pin did not halt");
	AST_PIN_RAMP: assert property (
		busy && accel_phase && near_act |-> ##[1:8] decel_phase)
		else $error("stop pin gave no ramp down");
endmodule : apd_axis_sva

bind apd_axis_profiler apd_axis_sva #(.SPD_W(SPD_W)) u_apd_axis_sva (
	.sys_clk(sys_clk),
	.rst_n(rst_n),
	.stop_input_mode_register(stop_input_mode_register),
	.initial_speed_param(initial_speed_param),
	.drive_speed(drive_speed),
	.start_fixed(start_fixed),
	.start_continuous(start_continuous),
	.decel_stop_cmd(decel_stop_cmd),
	.sudden_stop_cmd(sudden_stop_cmd),
	.near_home_stop_input(near_home_stop_input),
	.home_stop_input(home_stop_input),
	.drive_pulse(drive_pulse),
	.busy(busy),
	.accel_phase(accel_phase),
	.decel_phase(decel_phase),
	.current_speed(current_speed)
);

`default_nettype wire

// ===== tb/apd_motor_model.sv
`timescale 1ns/10ps
`default_nettype none

// Motor side: counts steps, trips sensors by position
module apd_motor_model #(
	parameter int NEAR_AT = 48,	// Near sensor trip point
	parameter int HOME_AT = 8	// Home sensor trip point
) (
	// Clock and reset
	input wire logic	sys_clk,
	input wire logic	rst_n,
	// Drive side
	input wire logic	clr,
	input wire logic	step,
	// Position and sensors
	output logic [31:0]	pos,
	output logic		near_sens,
	output logic		home_sens,
	output logic		z_sens_n
);
	logic step_reg;	// Last step level, for edge detect

	// Count rising step edges; a new start clears
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_reg <= 1'b0;
			pos <= 32'h0;
		end else begin
			step_reg <= step;
			if (clr)
				pos <= 32'h0;
			else if (step && !step_reg)
				pos <= pos + 32'h1;
		end
	end

	assign near_sens = pos >= NEAR_AT;
	assign home_sens = pos >= HOME_AT;
	// Active low once every four steps, like an index mark
	assign z_sens_n = pos[1:0] != 2'h3;
endmodule : apd_motor_model

`default_nettype wire

// ===== tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

// Self-checking bench for one axis profiler
module tb;
	logic		sys_clk;	// 20 MHz
	logic		rst_n;		// Async reset
	logic [5:0]	dm;		// Drive mode
	logic [5:0]	sm;		// Stop pin mode
	logic [15:0]	isp;		// Initial speed
	logic [15:0]	dsp;		// Drive speed
	logic [15:0]	arate;		// Ramp slope
	logic [15:0]	drate;		// Decel slope
	logic [15:0]	offv;		// Offset
	logic [31:0]	pcnt;		// Pulse count
	logic [31:0]	mpt;		// Manual point
	logic [5:0]	cmdv;		// Strobes
	logic		pulse;
	logic		busy;
	logic		acc;
	logic		dec;
	logic [15:0]	spd;
	logic [31:0]	pos;
	logic		near_s;
	logic		home_s;
	logic		z_s_n;
	int		err_total;
	int		compares;
	int		apos;		// Last count in ramp up
	int		dpos;		// Count at ramp down start

	apd_axis_profiler u_apd_axis_profiler (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.drive_mode_register(dm),
		.stop_input_mode_register(sm),
		.initial_speed_param(isp),
		.drive_speed(dsp),
		.accel_rate(arate),
		.decel_rate(drate),
		.pulse_count(pcnt),
		.pulse_count_write(cmdv[4]),
		.manual_decel_point(mpt),
		.offset_value(offv),
		.offset_write(cmdv[5]),
		.start_fixed(cmdv[0]),
		.start_continuous(cmdv[1]),
		.decel_stop_cmd(cmdv[2]),
		.sudden_stop_cmd(cmdv[3]),
		.near_home_stop_input(near_s),
		.home_stop_input(home_s),
		.z_phase_stop_input(z_s_n),
		.drive_pulse(pulse),
		.busy(busy),
		.accel_phase(acc),
		.decel_phase(dec),
		.current_speed(spd)
	);
	apd_motor_model u_apd_motor_model (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clr(cmdv[0] | cmdv[1]),
		.step(pulse),
		.pos(pos),
		.near_sens(near_s),
		.home_sens(home_s),
		.z_sens_n(z_s_n)
	);

	// Free running clock
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task give_verdict;
		if (err_total == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict

	task cmp_eq(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %0h want %0h", $time, got, exp);
		end
	endtask : cmp_eq

	task cmp_rng(input logic [31:0] got, lo, hi);
		compares++;
		if ($isunknown(got) || got < lo || got > hi) begin
			err_total++;
			$display("BAD %0t got %0h out of range", $time, got);
		end
	endtask : cmp_rng

	function automatic logic hit(input int w, input logic [31:0] v);
		if (w == 0)
			return busy === 1'b0;
		if (w == 1)
			return pos >= v;
		return {16'h0000, spd} === v;
	endfunction : hit

	// Bounded wait: idle, count reached, or speed reached
	task wait_on(input int w, input logic [31:0] v, input int lim);
		int i;
		compares++;
		for (i = 0; i < lim; i++) begin
			@(negedge sys_clk);
			if (hit(w, v))
				break;
		end
		@(posedge sys_clk);
		if (i == lim) begin
			err_total++;
			$display("BAD %0t wait ran out", $time);
			give_verdict();
		end
	endtask : wait_on

	// One-cycle strobe, then a gap so strobes never merge
	task fire(input logic [5:0] c);
		cmdv <= c;
		@(posedge sys_clk);
		cmdv <= 6'h00;
		@(posedge sys_clk);
	endtask : fire

	// Follow a drive to its end, noting phase change points
	task watch(input int lim);
		int i;
		apos = 0;
		dpos = 0;
		for (i = 0; i < lim; i++) begin
			@(negedge sys_clk);
			if (busy !== 1'b1)
				break;
			if (acc === 1'b1)
				apos = pos;
			if (dec === 1'b1 && dpos == 0)
				dpos = pos;
		end
		wait_on(0, 32'h0, 10);
	endtask : watch

	task run_fixed(input logic [5:0] m, input logic [31:0] lo, hi);
		dm <= m;
		pcnt <= 32'h78;
		fire(6'h01);
		watch(40000);
		cmp_eq(pos, 32'h78);
		cmp_rng(dpos, lo, hi);
	endtask : run_fixed

	task cont_stop(input logic [5:0] s, c, input logic [31:0] lo);
		dsp <= 16'hC000;
		fire(6'h02);
		repeat (4) @(posedge sys_clk);
		sm <= s;
		if (c != 6'h00) begin
			wait_on(1, lo, 8000);
			fire(c);
		end
		watch(40000);
		sm <= 6'h00;
		cmp_rng(dpos, lo, lo + 32'h2);
	endtask : cont_stop

	task cont_speed;
		dsp <= 16'h6000;
		fire(6'h02);
		wait_on(2, 32'h6000, 10000);
		dsp <= 16'h8000;
		wait_on(2, 32'h8000, 10000);
		fire(6'h08);
		wait_on(0, 32'h0, 40);
	endtask : cont_speed

	task pin_run(input logic [5:0] s, input logic [31:0] e);
		fire(6'h02);
		repeat (4) @(posedge sys_clk);
		dsp <= 16'h6000;
		repeat (2) @(posedge sys_clk);
		cmp_eq({16'h0000, spd}, 32'h6000);
		sm <= s;
		watch(8000);
		sm <= 6'h00;
		cmp_eq(pos, e);
	endtask : pin_run

	task cnt_run(input logic [31:0] n, at, nn, e);
		pcnt <= n;
		fire(6'h01);
		wait_on(1, at, 4000);
		pcnt <= nn;
		fire(6'h10);
		watch(4000);
		cmp_eq(pos, e);
	endtask : cnt_run

	// Main sequence
	initial begin
		rst_n = 1'b0;
		dm = 6'h00;
		sm = 6'h00;
		isp = 16'h4000;
		dsp = 16'hC000;
		arate = 16'h1000;
		drate = 16'h0000;
		offv = 16'h0000;
		pcnt = 32'h0;
		mpt = 32'h5A;
		cmdv = 6'h00;
		repeat (10) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		run_fixed(6'h00, 32'h37, 32'h39);
		cmp_rng(apos, 32'h36, 32'h39);
		offv <= 16'h0064;
		fire(6'h20);
		run_fixed(6'h00, 32'h9, 32'hB);
		offv <= 16'h0008;
		fire(6'h20);
		run_fixed(6'h01, 32'h1D, 32'h1F);
		run_fixed(6'h20, 32'h50, 32'h52);
		cmp_rng(apos, 32'h1E, 32'h20);
		drate <= 16'h2000;
		run_fixed(6'h02, 32'h1, 32'h78);
		run_fixed(6'h04, 32'h1, 32'h78);
		dm <= 6'h00;
		cont_stop(6'h03, 6'h00, 32'h30);
		cont_stop(6'h00, 6'h04, 32'h3C);
		cont_speed();
		isp <= 16'h8000;
		dsp <= 16'h8000;
		pin_run(6'h03, 32'h30);
		pin_run(6'h0C, 32'h8);
		pin_run(6'h10, 32'h3);
		cnt_run(32'hA, 32'h3, 32'h14, 32'h14);
		cnt_run(32'h28, 32'hA, 32'h2, 32'hA);
		cnt_run(32'h28, 32'hA, 32'hA, 32'hA);
		give_verdict();
	end
endmodule : tb

`default_nettype wire
